// ===== src/tmw_consts.svh
`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH
// Register byte offsets
`define TMW_OFS_CTRL_A 8'h00
`define TMW_OFS_CTRL_B 8'h04
`define TMW_OFS_COUNT 8'h08
`define TMW_OFS_CMP_A 8'h0C
`define TMW_OFS_CMP_B 8'h10
`define TMW_OFS_CAPT 8'h14
`define TMW_OFS_STAT 8'h18
`define TMW_OFS_MASK 8'h1C
// Field positions
`define TMW_CHA_MSB 7
`define TMW_CHA_LSB 6
`define TMW_CHB_MSB 5
`define TMW_CHB_LSB 4
`define TMW_WGH_MSB 4
`define TMW_WGH_LSB 3
`define TMW_WGL_MSB 1
`define TMW_WGL_LSB 0
`define TMW_CS_MSB 2
`define TMW_CS_LSB 0
`define TMW_ST_OVF 0
`define TMW_ST_CMPA 1
`define TMW_ST_CMPB 2
// Reset values and masks
`define TMW_RST_CTRL 8'h00
`define TMW_RST_WORD 16'h0000
`define TMW_RST_FLAGS 3'h0
`define TMW_RD_MASK_A 8'hF3
`define TMW_RD_MASK_B 8'h1F
// Count limits
`define TMW_BOTTOM 16'h0000
`define TMW_MAX 16'hFFFF
`define TMW_TOP_8 16'h00FF
`define TMW_TOP_9 16'h01FF
`define TMW_TOP_10 16'h03FF
`endif

// ===== src/tmw_mode_decode.sv
`include "tmw_consts.svh"
`default_nettype none
module tmw_mode_decode (
   input wire logic [3:0] i_waveform_mode,
   output tmw_pkg::tmw_family_t o_family,
   output tmw_pkg::tmw_top_src_t o_top_src,
   output logic [15:0] o_fixed_top
);
   // *****************************************
   // Mode table
   // *****************************************
   always_comb begin
      o_fixed_top = `TMW_MAX;
      o_top_src = tmw_pkg::TOP_FIXED;
      o_family = tmw_pkg::FAM_RSVD;
      unique case (i_waveform_mode)
         4'h0: o_family = tmw_pkg::FAM_NORMAL;
         4'h1: begin
            o_family = tmw_pkg::FAM_PHASE;
            o_fixed_top = `TMW_TOP_8;
         end
         4'h2: begin
            o_family = tmw_pkg::FAM_PHASE;
            o_fixed_top = `TMW_TOP_9;
         end
         4'h3: begin
            o_family = tmw_pkg::FAM_PHASE;
            o_fixed_top = `TMW_TOP_10;
         end
         4'h4: begin
            o_family = tmw_pkg::FAM_CTC;
            o_top_src = tmw_pkg::TOP_CMPA;
         end
         4'h5: begin
            o_family = tmw_pkg::FAM_FAST;
            o_fixed_top = `TMW_TOP_8;
         end
         4'h6: begin
            o_family = tmw_pkg::FAM_FAST;
            o_fixed_top = `TMW_TOP_9;
         end
         4'h7: begin
            o_family = tmw_pkg::FAM_FAST;
            o_fixed_top = `TMW_TOP_10;
         end
         4'h8: begin
            o_family = tmw_pkg::FAM_PFREQ;
            o_top_src = tmw_pkg::TOP_CAPT;
         end
         4'h9: begin
            o_family = tmw_pkg::FAM_PFREQ;
            o_top_src = tmw_pkg::TOP_CMPA;
         end
         4'hA: begin
            o_family = tmw_pkg::FAM_PHASE;
            o_top_src = tmw_pkg::TOP_CAPT;
         end
         4'hB: begin
            o_family = tmw_pkg::FAM_PHASE;
            o_top_src = tmw_pkg::TOP_CMPA;
         end
         4'hC: begin
            o_family = tmw_pkg::FAM_CTC;
            o_top_src = tmw_pkg::TOP_CAPT;
         end
         // Reserved code stops the counter
         4'hD: o_family = tmw_pkg::FAM_RSVD;
         4'hE: begin
            o_family = tmw_pkg::FAM_FAST;
            o_top_src = tmw_pkg::TOP_CAPT;
         end
         4'hF: begin
            o_family = tmw_pkg::FAM_FAST;
            o_top_src = tmw_pkg::TOP_CMPA;
         end
      endcase
   end
endmodule : tmw_mode_decode
`default_nettype wire

// ===== src/tmw_pkg.sv
`default_nettype none
package tmw_pkg;
   // Counting family picked by the four-bit waveform mode
   typedef enum logic [5:0] {
      FAM_NORMAL = 6'h01,
      FAM_CTC = 6'h02,
      FAM_FAST = 6'h04,
      FAM_PHASE = 6'h08,
      FAM_PFREQ = 6'h10,
      FAM_RSVD = 6'h20
   } tmw_family_t;
   // Source of the top value
   typedef enum logic [2:0] {
      TOP_FIXED = 3'h1,
      TOP_CMPA = 3'h2,
      TOP_CAPT = 3'h4
   } tmw_top_src_t;
endpackage : tmw_pkg
`default_nettype wire

// ===== src/tmw_top.sv
`include "tmw_consts.svh"
`default_nettype none
// Summary of operation
// - All logic on the system clock; the tick only enables counting.
// - Nonzero channel output mode takes the pin from general-purpose use.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 01 toggles channel A only in modes 14 and 15.
// - Fast PWM 10 clears on match, sets at top; 11 inverse.
// - Fast PWM 10/11 compare equal to top: match ignored, only top action.
// - Dual-slope 01 toggles channel A only in modes 8 to 11.
// - Dual-slope 10 clears on up-count match, sets on down; 11 inverse.
// - Low mode bits 1:0 of control A join high bits of B.
// - Normal and clear-on-match modes update immediately, overflow at MAX.
// - Phase correct modes reload at top, overflow at bottom.
// - Fast PWM modes reload at top and overflow at top.
// - Phase-and-frequency modes reload at bottom, overflow at bottom.
// - High mode bits sit at bits 4:3 of control B.
module tmw_top (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_clk_en,
   input wire logic i_timer_tick_enable,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_compare_out_a,
   output logic o_compare_out_b,
   output logic o_pin_override_a,
   output logic o_pin_override_b,
   output logic o_irq
);
   // *****************************************
   // Declarations
   // *****************************************
   logic [7:0] waveform_output_control_a, next_ctrl_a;
   logic [7:0] waveform_clock_control_b, next_ctrl_b;
   logic [15:0] count_value, next_count;
   logic [15:0] cmp_buf [2], next_buf [2];
   logic [15:0] cmp_act [2], next_act [2];
   logic [15:0] capture_value, next_capt;
   logic [2:0] int_status, next_status;
   logic [2:0] int_mask, next_mask;
   logic count_up, next_up;
   logic match_block, next_block;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_irq;
   logic next_ovr_a, next_ovr_b;
   logic [3:0] waveform_mode;
   tmw_pkg::tmw_family_t family;
   tmw_pkg::tmw_top_src_t top_src;
   logic [15:0] fixed_top, top_value;
   logic tick, at_top, at_bottom, ovf_event;
   logic [1:0] match;
   logic [1:0] chan_mode [2];
   logic [1:0] wave;
   logic setup, wr, mapped;

   // *****************************************
   // Mode decode and top select
   // *****************************************
   assign waveform_mode = {
      waveform_clock_control_b[`TMW_WGH_MSB:`TMW_WGH_LSB],
      waveform_output_control_a[`TMW_WGL_MSB:`TMW_WGL_LSB]};
   assign chan_mode[0] =
      waveform_output_control_a[`TMW_CHA_MSB:`TMW_CHA_LSB];
   assign chan_mode[1] =
      waveform_output_control_a[`TMW_CHB_MSB:`TMW_CHB_LSB];

   tmw_mode_decode u_decode (
      .i_waveform_mode(waveform_mode),
      .o_family(family),
      .o_top_src(top_src),
      .o_fixed_top(fixed_top)
   );

   // Tick is a qualifier only; a zero clock select stops the count
   assign tick = i_timer_tick_enable && (waveform_clock_control_b[
      `TMW_CS_MSB:`TMW_CS_LSB] != 3'h0);

   always_comb begin
      top_value = fixed_top;
      unique case (top_src)
         tmw_pkg::TOP_FIXED: top_value = fixed_top;
         tmw_pkg::TOP_CMPA: top_value = cmp_act[0];
         tmw_pkg::TOP_CAPT: top_value = capture_value;
      endcase
   end

   assign at_top = (count_value == top_value);
   assign at_bottom = (count_value == `TMW_BOTTOM);

   // *****************************************
   // Register bus
   // *****************************************
   // No wait state: pready rises in the first access-phase cycle
   assign setup = i_psel && !i_penable;
   assign wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

   always_comb begin
      mapped = 1'b1;
      next_prdata = 32'h0000_0000;
      unique case (i_paddr)
         `TMW_OFS_CTRL_A: next_prdata[7:0] =
            waveform_output_control_a & `TMW_RD_MASK_A;
         `TMW_OFS_CTRL_B: next_prdata[7:0] =
            waveform_clock_control_b & `TMW_RD_MASK_B;
         `TMW_OFS_COUNT: next_prdata[15:0] = count_value;
         `TMW_OFS_CMP_A: next_prdata[15:0] = cmp_buf[0];
         `TMW_OFS_CMP_B: next_prdata[15:0] = cmp_buf[1];
         `TMW_OFS_CAPT: next_prdata[15:0] = capture_value;
         `TMW_OFS_STAT: next_prdata[2:0] = int_status;
         `TMW_OFS_MASK: next_prdata[2:0] = int_mask;
         default: mapped = 1'b0;
      endcase
      if (!setup)
         next_prdata = o_prdata;
      next_pready = setup;
      next_pslverr = setup && !mapped;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_prdata <= 32'h0000_0000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else if (i_clk_en) begin
         o_prdata <= next_prdata;
         o_pready <= next_pready;
         o_pslverr <= next_pslverr;
      end
   end

   // *****************************************
   // Control registers
   // *****************************************
   always_comb begin
      next_ctrl_a = waveform_output_control_a;
      next_ctrl_b = waveform_clock_control_b;
      next_mask = int_mask;
      next_capt = capture_value;
      if (wr && i_paddr == `TMW_OFS_CTRL_A)
         next_ctrl_a = i_pwdata[7:0] & `TMW_RD_MASK_A;
      if (wr && i_paddr == `TMW_OFS_CTRL_B)
         next_ctrl_b = i_pwdata[7:0] & `TMW_RD_MASK_B;
      if (wr && i_paddr == `TMW_OFS_MASK)
         next_mask = i_pwdata[2:0];
      if (wr && i_paddr == `TMW_OFS_CAPT)
         next_capt = i_pwdata[15:0];
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         waveform_output_control_a <= `TMW_RST_CTRL;
         waveform_clock_control_b <= `TMW_RST_CTRL;
         int_mask <= `TMW_RST_FLAGS;
         capture_value <= `TMW_RST_WORD;
      end else if (i_clk_en) begin
         waveform_output_control_a <= next_ctrl_a;
         waveform_clock_control_b <= next_ctrl_b;
         int_mask <= next_mask;
         capture_value <= next_capt;
      end
   end

   // *****************************************
   // Counter
   // *****************************************
   // A software write wins over the tick and blocks the next match
   always_comb begin
      next_count = count_value;
      next_up = count_up;
      next_block = match_block;
      ovf_event = 1'b0;
      if (tick) begin
         next_block = 1'b0;
         unique case (family)
            tmw_pkg::FAM_NORMAL, tmw_pkg::FAM_CTC: begin
               next_up = 1'b1;
               next_count = at_top ? `TMW_BOTTOM : count_value + 16'h0001;
               ovf_event = (count_value == `TMW_MAX);
            end
            tmw_pkg::FAM_FAST: begin
               next_up = 1'b1;
               next_count = at_top ? `TMW_BOTTOM : count_value + 16'h0001;
               ovf_event = at_top;
            end
            tmw_pkg::FAM_PHASE, tmw_pkg::FAM_PFREQ: begin
               ovf_event = at_bottom && !count_up;
               if (count_up && at_top) begin
                  next_up = 1'b0;
                  next_count = count_value - 16'h0001;
               end else if (!count_up && at_bottom) begin
                  next_up = 1'b1;
                  next_count = count_value + 16'h0001;
               end else if (count_up) begin
                  next_count = count_value + 16'h0001;
               end else begin
                  next_count = count_value - 16'h0001;
               end
            end
            tmw_pkg::FAM_RSVD: next_count = count_value;
         endcase
      end
      if (wr && i_paddr == `TMW_OFS_COUNT) begin
         next_count = i_pwdata[15:0];
         next_block = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         count_value <= `TMW_RST_WORD;
         count_up <= 1'b1;
         match_block <= 1'b0;
      end else if (i_clk_en) begin
         count_value <= next_count;
         count_up <= next_up;
         match_block <= next_block;
      end
   end

   // *****************************************
   // Compare channels
   // *****************************************
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         localparam logic [7:0] OFS = (ch == 0) ? `TMW_OFS_CMP_A
            : `TMW_OFS_CMP_B;
         assign match[ch] = tick && !match_block
            && (count_value == cmp_act[ch]);
         // Double buffering keeps a PWM period glitch-free; normal and CTC load a new value at once
         always_comb begin
            next_buf[ch] = cmp_buf[ch];
            next_act[ch] = cmp_act[ch];
            if (wr && i_paddr == OFS)
               next_buf[ch] = i_pwdata[15:0];
            unique case (family)
               tmw_pkg::FAM_NORMAL, tmw_pkg::FAM_CTC:
                  next_act[ch] = next_buf[ch];
               tmw_pkg::FAM_FAST, tmw_pkg::FAM_PHASE: begin
                  if (tick && at_top)
                     next_act[ch] = cmp_buf[ch];
               end
               tmw_pkg::FAM_PFREQ: begin
                  if (tick && at_bottom)
                     next_act[ch] = cmp_buf[ch];
               end
               tmw_pkg::FAM_RSVD: next_act[ch] = cmp_act[ch];
            endcase
         end
         always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
               cmp_buf[ch] <= `TMW_RST_WORD;
               cmp_act[ch] <= `TMW_RST_WORD;
            end else if (i_clk_en) begin
               cmp_buf[ch] <= next_buf[ch];
               cmp_act[ch] <= next_act[ch];
            end
         end
         tmw_wave_out #(.IS_CHAN_A(ch == 0)) u_wave (
            .i_sys_clk(i_sys_clk),
            .i_srst(i_srst),
            .i_clk_en(i_clk_en),
            .i_chan_output_mode(chan_mode[ch]),
            .i_waveform_mode(waveform_mode),
            .i_family(family),
            .i_match(match[ch]),
            .i_top_hit(tick && at_top),
            .i_count_up(count_up),
            .o_wave(wave[ch])
         );
      end
   endgenerate

   assign o_compare_out_a = wave[0];
   assign o_compare_out_b = wave[1];

   // *****************************************
   // Flags, interrupt and pin override
   // *****************************************
   // Set beats a same-cycle write-one clear
   always_comb begin
      next_status = int_status;
      if (wr && i_paddr == `TMW_OFS_STAT)
         next_status = int_status & ~i_pwdata[2:0];
      next_status[`TMW_ST_OVF] = next_status[`TMW_ST_OVF]
         | ovf_event;
      next_status[`TMW_ST_CMPA] = next_status[`TMW_ST_CMPA] | match[0];
      next_status[`TMW_ST_CMPB] = next_status[`TMW_ST_CMPB] | match[1];
      next_irq = |(next_status & next_mask);
      next_ovr_a = |next_ctrl_a[`TMW_CHA_MSB:`TMW_CHA_LSB];
      next_ovr_b = |next_ctrl_a[`TMW_CHB_MSB:`TMW_CHB_LSB];
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         int_status <= `TMW_RST_FLAGS;
         o_irq <= 1'b0;
         o_pin_override_a <= 1'b0;
         o_pin_override_b <= 1'b0;
      end else if (i_clk_en) begin
         int_status <= next_status;
         o_irq <= next_irq;
         o_pin_override_a <= next_ovr_a;
         o_pin_override_b <= next_ovr_b;
      end
   end

   // *****************************************
   // Assertions
   // *****************************************
   a_tick_only_count: assert property (@(posedge i_sys_clk)
      disable iff (i_srst) i_clk_en && !tick
      && !(wr && i_paddr == `TMW_OFS_COUNT) |=> $stable(count_value))
      else $error("count moved without tick");
   a_override_pin: assert property (@(posedge i_sys_clk)
      disable iff (i_srst) i_clk_en |=> o_pin_override_a
      == (|$past(next_ctrl_a[`TMW_CHA_MSB:`TMW_CHA_LSB])))
      else $error("override not from mode");
   a_normal_ovf: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && tick && !wr && family == tmw_pkg::FAM_NORMAL
      && count_value == `TMW_MAX |=> int_status[`TMW_ST_OVF]
      && count_value == `TMW_BOTTOM)
      else $error("normal overflow missed");
   a_dual_turn: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && tick && family == tmw_pkg::FAM_PHASE && count_up
      && at_top && !wr |=> !count_up)
      else $error("no turn at top");
   a_fast_reload: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && tick && family == tmw_pkg::FAM_FAST && at_top
      |=> int_status[`TMW_ST_OVF] && cmp_act[1] == $past(cmp_buf[1]))
      else $error("fast pwm top events missed");
   a_pfreq_ovf: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && tick && family == tmw_pkg::FAM_PFREQ && !count_up
      && at_bottom |=> int_status[`TMW_ST_OVF]
      && cmp_act[1] == $past(cmp_buf[1]))
      else $error("bottom events missed");
   a_rsvd_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && family == tmw_pkg::FAM_RSVD && !wr
      |=> $stable(count_value))
      else $error("reserved mode counted");
   a_cmp_flag_next: assert property (@(posedge i_sys_clk)
      disable iff (i_srst) i_clk_en && match[1]
      |=> int_status[`TMW_ST_CMPB] ##1 (int_status[`TMW_ST_CMPB]
      || $past(wr)))
      else $error("compare flag late");
endmodule : tmw_top
`default_nettype wire

// ===== src/tmw_wave_out.sv
`default_nettype none
module tmw_wave_out #(
   parameter bit IS_CHAN_A = 1'b1
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_clk_en,
   input wire logic [1:0] i_chan_output_mode,
   input wire logic [3:0] i_waveform_mode,
   input wire tmw_pkg::tmw_family_t i_family,
   input wire logic i_match,
   input wire logic i_top_hit,
   input wire logic i_count_up,
   output logic o_wave
);
   logic next_wave;
   logic toggle_ok;

   // *****************************************
   // Output waveform
   // *****************************************
   // Toggle in PWM families exists only on A, in modes 8 to 11, 14 and 15
   always_comb begin
      next_wave = o_wave;
      toggle_ok = 1'b0;
      unique case (i_family)
         tmw_pkg::FAM_NORMAL, tmw_pkg::FAM_CTC: begin
            if (i_match) begin
               unique case (i_chan_output_mode)
                  2'h0: next_wave = o_wave;
                  2'h1: next_wave = ~o_wave;
                  2'h2: next_wave = 1'b0;
                  2'h3: next_wave = 1'b1;
               endcase
            end
         end
         tmw_pkg::FAM_FAST: begin
            toggle_ok = IS_CHAN_A && (i_waveform_mode >= 4'hE);
            if (i_chan_output_mode == 2'h1) begin
               if (i_match && toggle_ok)
                  next_wave = ~o_wave;
            end else if (i_chan_output_mode[1]) begin
               // Top wins, so a match equal to top is ignored
               if (i_top_hit)
                  next_wave = ~i_chan_output_mode[0];
               else if (i_match)
                  next_wave = i_chan_output_mode[0];
            end
         end
         tmw_pkg::FAM_PHASE, tmw_pkg::FAM_PFREQ: begin
            toggle_ok = IS_CHAN_A && (i_waveform_mode >= 4'h8)
               && (i_waveform_mode <= 4'hB);
            if (i_match) begin
               if (i_chan_output_mode == 2'h1) begin
                  if (toggle_ok)
                     next_wave = ~o_wave;
               end else if (i_chan_output_mode[1]) begin
                  next_wave = i_chan_output_mode[0] ^ ~i_count_up;
               end
            end
         end
         tmw_pkg::FAM_RSVD: next_wave = o_wave;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst)
         o_wave <= 1'b0;
      else if (i_clk_en)
         o_wave <= next_wave;
   end

   a_nonpwm_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && i_family == tmw_pkg::FAM_NORMAL && i_match
      && i_chan_output_mode == 2'h3 |=> o_wave)
      else $error("set on match missed");
   a_fast_top_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && i_family == tmw_pkg::FAM_FAST && i_top_hit
      && i_chan_output_mode == 2'h2 |=> o_wave)
      else $error("fast pwm top set missed");
   a_dual_up_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_clk_en && i_family == tmw_pkg::FAM_PHASE && i_match && i_count_up
      && i_chan_output_mode == 2'h2 |=> !o_wave)
      else $error("up-count clear missed");
   a_b_no_toggle: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      !IS_CHAN_A && i_family != tmw_pkg::FAM_NORMAL
      && i_family != tmw_pkg::FAM_CTC && i_chan_output_mode == 2'h1
      |=> $stable(o_wave))
      else $error("channel b toggled in pwm");
endmodule : tmw_wave_out
`default_nettype wire

// ===== verification/test_timer16_waveform_mode_control.sv
`include "tmw_consts.svh"
`default_nettype none
module test_timer16_waveform_mode_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, srst = 1'b1, tk = 1'b0, dir = 1'b0, en = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, out_a, out_b, ovr_a, ovr_b, irq, pin_a;
   int fail_count = 0;
   int cmp_count = 0;
   // Enable is driven so the freeze scenario can stall the block
   tmw_top dut_u (.i_sys_clk(clk), .i_srst(srst), .i_clk_en(en),
      .i_timer_tick_enable(tk), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_compare_out_a(out_a), .o_compare_out_b(out_b),
      .o_pin_override_a(ovr_a), .o_pin_override_b(ovr_b), .o_irq(irq));
   tmw_pin_load load_u (.i_dir_out(dir), .i_override(ovr_a),
      .i_wave(out_a), .i_gpio(1'b0), .o_pin_level(pin_a));
   // ****
   // Shared tasks
   // ****
   initial forever #20 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] e, input logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n == 16) fail_count++;
      if (!w) chk(prdata, e);
      chk({31'h0, pslverr}, {31'h0, er});
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Extra idle edge lets the last tick's updates land before checks
   task automatic tick(input int n);
      tk <= 1'b1;
      repeat (n) @(posedge clk);
      tk <= 1'b0;
      @(posedge clk);
   endtask : tick
   task automatic finish_test;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   // ****
   // Scenarios
   // ****
   task automatic t_regs;
      apb(0, `TMW_OFS_CTRL_A, 0, 0, 0);
      apb(0, `TMW_OFS_CTRL_B, 0, 0, 0);
      apb(1, `TMW_OFS_CTRL_A, 32'hFF, 0, 0);
      apb(0, `TMW_OFS_CTRL_A, 0, 32'hF3, 0);
      chk({31'h0, ovr_a}, 32'h1);
      apb(1, `TMW_OFS_CTRL_B, 32'hFF, 0, 0);
      apb(0, `TMW_OFS_CTRL_B, 0, 32'h1F, 0);
      apb(1, `TMW_OFS_CTRL_B, 0, 0, 0);
      apb(1, `TMW_OFS_CTRL_A, 0, 0, 0);
      chk({31'h0, ovr_a}, 32'h0);
      apb(0, 8'h20, 0, 0, 1);
      $display("register test done");
   endtask : t_regs
   task automatic t_ovf;
      apb(1, `TMW_OFS_MASK, 32'h1, 0, 0);
      apb(1, `TMW_OFS_COUNT, 32'hFFFF, 0, 0);
      apb(1, `TMW_OFS_CTRL_B, 32'h1, 0, 0);
      tick(1);
      apb(0, `TMW_OFS_COUNT, 0, 0, 0);
      apb(0, `TMW_OFS_STAT, 0, 32'h1, 0);
      chk({31'h0, irq}, 32'h1);
      apb(1, `TMW_OFS_STAT, 32'h1, 0, 0);
      chk({31'h0, irq}, 32'h0);
      $display("overflow test done");
   endtask : t_ovf
   // Toggle from low, then clear, then set, each on a match at 5
   task automatic t_out;
      logic [1:0] m;
      apb(1, `TMW_OFS_CMP_A, 32'h5, 0, 0);
      dir <= 1'b1;
      for (int i = 1; i < 4; i++) begin
         m = 2'(i);
         apb(1, `TMW_OFS_CTRL_A, {24'h0, m, 6'h0}, 0, 0);
         apb(1, `TMW_OFS_COUNT, 32'h3, 0, 0);
         tick(3);
         chk({31'h0, pin_a}, {31'h0, m != 2'h2});
         chk({31'h0, ovr_b}, 32'h0);
      end
      $display("output mode test done");
   endtask : t_out
   task automatic t_fast;
      apb(1, `TMW_OFS_CTRL_B, 0, 0, 0);
      apb(1, `TMW_OFS_CTRL_A, 32'hB1, 0, 0);
      apb(1, `TMW_OFS_CTRL_B, 32'h9, 0, 0);
      apb(1, `TMW_OFS_COUNT, 32'h3, 0, 0);
      tick(3);
      chk({31'h0, pin_a}, 32'h0);
      apb(1, `TMW_OFS_STAT, 32'h7, 0, 0);
      tick(250);
      chk({31'h0, pin_a}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      tick(6);
      chk({31'h0, pin_a}, 32'h0);
      chk({31'h0, out_b}, 32'h1);
      $display("fast pwm test done");
   endtask : t_fast
   // Enable low with ticks running must leave the count alone
   task automatic t_freeze;
      en <= 1'b0;
      tk <= 1'b1;
      repeat (4) @(posedge clk);
      en <= 1'b1;
      tk <= 1'b0;
      @(posedge clk);
      apb(0, `TMW_OFS_COUNT, 0, 32'h6, 0);
      $display("clock enable test done");
   endtask : t_freeze
   // Dual slope, top from compare A at 5, channel B inverted at 2
   task automatic t_dual;
      apb(1, `TMW_OFS_CTRL_B, 0, 0, 0);
      apb(1, `TMW_OFS_CTRL_A, 32'hB3, 0, 0);
      apb(1, `TMW_OFS_CMP_B, 32'h2, 0, 0);
      apb(1, `TMW_OFS_STAT, 32'h7, 0, 0);
      apb(1, `TMW_OFS_COUNT, 32'h0, 0, 0);
      apb(1, `TMW_OFS_CTRL_B, 32'h11, 0, 0);
      tick(9);
      chk({31'h0, out_b}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      tick(4);
      chk({31'h0, out_b}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(0, `TMW_OFS_COUNT, 0, 32'h3, 0);
      $display("dual slope test done");
   endtask : t_dual
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_ovf;
      t_out;
      t_fast;
      t_freeze;
      t_dual;
      finish_test;
   end
   // Whole run is well under 2000 cycles
   initial begin
      #200000;
      fail_count++;
      finish_test;
   end
endmodule : test_timer16_waveform_mode_control
`default_nettype wire

// ===== verification/tmw_pin_load.sv
`default_nettype none
// ****
// Load on one compare output pin
// ****
module tmw_pin_load (
   input wire logic i_dir_out,
   input wire logic i_override,
   input wire logic i_wave,
   input wire logic i_gpio,
   output logic o_pin_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // Driver off leaves the pull-up in charge, never a stale level
   assign o_pin_level = !i_dir_out ? 1'b1
      : (i_override ? i_wave : i_gpio);
endmodule : tmw_pin_load
`default_nettype wire
